// [design/retc_pkg.sv]
// Constants shared by the event timestamp capture block
// Summary of operation
// - Detect input entering mid level from either side
// - Mid-level event stores time, sets level flag
// - Enabled stamp interrupt follows set event flags
// - Software clears level flag, interrupt withdrawn
// - Level flag resets only on new edge
// - Ground event stores time, sets both flags
// - Interrupt stays until both flags cleared
// - Ground flag resets only on new ground
// - Order select: zero keeps last, one first
// - Active after power-on; disable bit stops it
// - Control register: subsecond, order, disable bits
// - Seconds stamp BCD, bit seven reads zero
// - Minutes stamp BCD, bit seven reads zero
// - Hours stamp BCD, 12h uses afternoon bit
// - Hour format follows main control select
// - Unimplemented stamp bits read as zero
// - Stamp data not reset; control bits are
// - Battery capture with switch flag ignores events
package retc_pkg;

    localparam logic [7:0] ADDR_STAMP_CONTROL = 8'h12;
    localparam logic [7:0] ADDR_STAMP_SECONDS = 8'h13;
    localparam logic [7:0] ADDR_STAMP_MINUTES = 8'h14;
    localparam logic [7:0] ADDR_STAMP_HOURS   = 8'h15;

    localparam int CTL_ORDER_BIT   = 7;
    localparam int CTL_DISABLE_BIT = 6;
    localparam int HOUR_PM_BIT     = 5;

    localparam logic RST_ORDER_SELECT   = 1'h0;
    localparam logic RST_CAPTURE_DIS    = 1'h0;
    localparam logic RST_FLAG           = 1'h0;

    localparam int SYNC_STAGES_DEFAULT = 2;

    typedef enum logic [1:0] {
        LVL_HIGH = 2'b00,
        LVL_MID  = 2'b01,
        LVL_GND  = 2'b10
    } retc_level_t;

endpackage

// [design/retc_event_detect.sv]
// Synchroniser and level classifier for the multilevel event input
`timescale 1ns/10ps
module retc_event_detect #(
    parameter int SYNC_STAGES = retc_pkg::SYNC_STAGES_DEFAULT
) (
    input  wire logic clk_sys,
    input  wire logic resetn,
    input  wire logic event_input_n_below_mid,
    input  wire logic event_input_n_at_ground,
    output logic      level_event,
    output logic      ground_event
);

    if (SYNC_STAGES < 2) begin : g_check
        $error("SYNC_STAGES must be at least 2");
    end

    logic [SYNC_STAGES-1:0][1:0] chain;
    logic [SYNC_STAGES-1:0][1:0] next_chain;
    retc_pkg::retc_level_t       prev_level;
    retc_pkg::retc_level_t       cur_level;
    logic                        next_level_event;
    logic                        next_ground_event;

    always_comb begin
        next_chain = {chain[SYNC_STAGES-2:0], {event_input_n_at_ground, event_input_n_below_mid}};
        // Ground comparator dominates an inconsistent pair
        if (chain[SYNC_STAGES-1][1]) begin
            cur_level = retc_pkg::LVL_GND;
        end else if (chain[SYNC_STAGES-1][0]) begin
            cur_level = retc_pkg::LVL_MID;
        end else begin
            cur_level = retc_pkg::LVL_HIGH;
        end
        next_level_event  = 1'b0;
        next_ground_event = 1'b0;
        unique case (cur_level)
            retc_pkg::LVL_MID: begin
                next_level_event = (prev_level != retc_pkg::LVL_MID);
            end
            retc_pkg::LVL_GND: begin
                next_ground_event = (prev_level != retc_pkg::LVL_GND);
            end
            retc_pkg::LVL_HIGH: begin
                next_level_event = 1'b0;
            end
            default: begin
                next_level_event = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            chain        <= '0;
            prev_level   <= retc_pkg::LVL_HIGH;
            level_event  <= 1'b0;
            ground_event <= 1'b0;
        end else begin
            chain        <= next_chain;
            prev_level   <= cur_level;
            level_event  <= next_level_event;
            ground_event <= next_ground_event;
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    property p_single_level_pulse;
        level_event |=> !level_event;
    endproperty
    a_single_level_pulse: assert property (p_single_level_pulse) else $error("level event longer than one cycle");

    property p_mid_entry;
        (cur_level == retc_pkg::LVL_MID) && (prev_level == retc_pkg::LVL_HIGH) |=> level_event;
    endproperty
    a_mid_entry: assert property (p_mid_entry) else $error("mid entry from high missed");

    property p_single_ground_pulse;
        ground_event |=> !ground_event;
    endproperty
    a_single_ground_pulse: assert property (p_single_ground_pulse) else $error("ground event longer than one cycle");

endmodule

// [design/retc_hour_format.sv]
// Converts the 24-hour BCD time to the selected stamp hour format
`timescale 1ns/10ps
module retc_hour_format (
    input  wire logic       hour_mode_12,
    input  wire logic [5:0] hours_24,
    output logic [5:0]      hours_out
);

    function automatic logic [4:0] bcd_to_bin(input logic [5:0] b);
        return 5'(5'(b[5:4]) * 5'd10 + 5'(b[3:0]));
    endfunction

    function automatic logic [5:0] bin_to_bcd(input logic [4:0] v);
        logic [1:0] tens;
        tens = (v >= 5'd20) ? 2'h2 : ((v >= 5'd10) ? 2'h1 : 2'h0);
        return {tens, 4'(v - 5'(5'(tens) * 5'd10))};
    endfunction

    logic [4:0] hour_bin;
    logic [4:0] hour_12;
    logic       afternoon_indicator;
    logic [5:0] hour_12_bcd;

    always_comb begin
        hour_bin            = bcd_to_bin(hours_24);
        afternoon_indicator = (hour_bin >= 5'd12);
        if (hour_bin == 5'd0) begin
            hour_12 = 5'd12;
        end else if (hour_bin > 5'd12) begin
            hour_12 = 5'(hour_bin - 5'd12);
        end else begin
            hour_12 = hour_bin;
        end
        hour_12_bcd = bin_to_bcd(hour_12);
        if (hour_mode_12) begin
            hours_out = {afternoon_indicator, hour_12_bcd[4:0]};
        end else begin
            hours_out = bin_to_bcd(hour_bin);
        end
    end

endmodule

// [design/retc_capture.sv]
// Event timestamp capture: flags, stamp registers and interrupt
`timescale 1ns/10ps
module retc_capture #(
    parameter int SYNC_STAGES = retc_pkg::SYNC_STAGES_DEFAULT
) (
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    input  wire logic       event_input_n_below_mid,
    input  wire logic       event_input_n_at_ground,
    input  wire logic [4:0] now_subsec,
    input  wire logic [6:0] now_seconds,
    input  wire logic [6:0] now_minutes,
    input  wire logic [5:0] now_hours_24,
    input  wire logic       hour_mode_12,
    input  wire logic       stamp_irq_enable,
    input  wire logic       battery_capture_enable,
    input  wire logic       battery_switch_flag,
    input  wire logic       clear_level_event_flag,
    input  wire logic       clear_ground_event_flag,
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_write,
    input  wire logic [7:0] reg_wdata,
    output logic [7:0]      reg_rdata,
    output logic            level_event_flag,
    output logic            ground_event_flag,
    output logic            stamp_irq
);

    if (SYNC_STAGES < 2) begin : g_check
        $error("SYNC_STAGES must be at least 2");
    end

    logic       level_event;
    logic       ground_event;
    logic [5:0] hours_fmt;

    logic       capture_order_select;
    logic       capture_disable;
    logic [4:0] stamp_subsec;
    logic [6:0] stamp_seconds;
    logic [6:0] stamp_minutes;
    logic [5:0] stamp_hours;

    logic       next_capture_order_select;
    logic       next_capture_disable;
    logic       next_level_event_flag;
    logic       next_ground_event_flag;
    logic       next_stamp_irq;
    logic [7:0] next_reg_rdata;
    logic [4:0] next_stamp_subsec;
    logic [6:0] next_stamp_seconds;
    logic [6:0] next_stamp_minutes;
    logic [5:0] next_stamp_hours;

    logic       take_ok;
    logic       accept;
    logic       kept_level;
    logic       kept_ground;
    logic       store;
    logic       ctl_write;

    retc_event_detect #(
        .SYNC_STAGES (SYNC_STAGES)
    ) u_detect (
        .clk_sys                 (clk_sys),
        .resetn                  (resetn),
        .event_input_n_below_mid (event_input_n_below_mid),
        .event_input_n_at_ground (event_input_n_at_ground),
        .level_event             (level_event),
        .ground_event            (ground_event)
    );

    retc_hour_format u_hour (
        .hour_mode_12 (hour_mode_12),
        .hours_24     (now_hours_24),
        .hours_out    (hours_fmt)
    );

    // Control and flag state
    always_comb begin
        ctl_write = reg_write && (reg_addr == retc_pkg::ADDR_STAMP_CONTROL);
        next_capture_order_select = capture_order_select;
        next_capture_disable      = capture_disable;
        if (ctl_write) begin
            next_capture_order_select = reg_wdata[retc_pkg::CTL_ORDER_BIT];
            next_capture_disable      = reg_wdata[retc_pkg::CTL_DISABLE_BIT];
        end
        // Disabled function or a latched battery capture blocks all events
        take_ok = !capture_disable && !(battery_capture_enable && battery_switch_flag);
        accept  = take_ok && (level_event || ground_event);
        kept_level  = level_event_flag && !clear_level_event_flag;
        kept_ground = ground_event_flag && !clear_ground_event_flag;
        // Set wins over a clear in the same cycle
        next_level_event_flag  = kept_level || accept;
        next_ground_event_flag = kept_ground || (take_ok && ground_event);
        // First-event mode holds the stamp while any flag stays set
        store = accept && (!capture_order_select || !(kept_level || kept_ground));
        next_stamp_irq = stamp_irq_enable && (next_level_event_flag || next_ground_event_flag);
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            capture_order_select <= retc_pkg::RST_ORDER_SELECT;
            capture_disable      <= retc_pkg::RST_CAPTURE_DIS;
            level_event_flag     <= retc_pkg::RST_FLAG;
            ground_event_flag    <= retc_pkg::RST_FLAG;
            stamp_irq            <= 1'b0;
        end else begin
            capture_order_select <= next_capture_order_select;
            capture_disable      <= next_capture_disable;
            level_event_flag     <= next_level_event_flag;
            ground_event_flag    <= next_ground_event_flag;
            stamp_irq            <= next_stamp_irq;
        end
    end

    // Stamp data: one joint load, no reset
    always_comb begin
        next_stamp_subsec  = stamp_subsec;
        next_stamp_seconds = stamp_seconds;
        next_stamp_minutes = stamp_minutes;
        next_stamp_hours   = stamp_hours;
        if (store) begin
            next_stamp_subsec  = now_subsec;
            next_stamp_seconds = now_seconds;
            next_stamp_minutes = now_minutes;
            next_stamp_hours   = hours_fmt;
        end
    end

    always_ff @(posedge clk_sys) begin
        stamp_subsec  <= next_stamp_subsec;
        stamp_seconds <= next_stamp_seconds;
        stamp_minutes <= next_stamp_minutes;
        stamp_hours   <= next_stamp_hours;
    end

    // Register read path, one cycle latency
    always_comb begin
        unique case (reg_addr)
            retc_pkg::ADDR_STAMP_CONTROL: begin
                next_reg_rdata = {capture_order_select, capture_disable, 1'b0, stamp_subsec};
            end
            retc_pkg::ADDR_STAMP_SECONDS: begin
                next_reg_rdata = {1'b0, stamp_seconds};
            end
            retc_pkg::ADDR_STAMP_MINUTES: begin
                next_reg_rdata = {1'b0, stamp_minutes};
            end
            retc_pkg::ADDR_STAMP_HOURS: begin
                next_reg_rdata = {2'b00, stamp_hours};
            end
            default: begin
                next_reg_rdata = 8'h00;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= next_reg_rdata;
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    property p_level_sets_flag;
        take_ok && level_event |=> level_event_flag;
    endproperty
    a_level_sets_flag: assert property (p_level_sets_flag) else $error("level event did not set flag");

    property p_irq_follows;
        stamp_irq == ($past(stamp_irq_enable) && (level_event_flag || ground_event_flag));
    endproperty
    a_irq_follows: assert property (p_irq_follows) else $error("interrupt does not follow flags");

    property p_clear_level;
        level_event_flag && clear_level_event_flag && !accept |=> !level_event_flag;
    endproperty
    a_clear_level: assert property (p_clear_level) else $error("level flag not cleared");

    property p_level_rise_cause;
        $rose(level_event_flag) |-> $past(accept);
    endproperty
    a_level_rise_cause: assert property (p_level_rise_cause) else $error("level flag set without event");

    property p_ground_sets_both;
        take_ok && ground_event |=> level_event_flag && ground_event_flag;
    endproperty
    a_ground_sets_both: assert property (p_ground_sets_both) else $error("ground event flags wrong");

    property p_irq_held_by_ground;
        $past(stamp_irq_enable) && ground_event_flag && !level_event_flag |-> stamp_irq;
    endproperty
    a_irq_held_by_ground: assert property (p_irq_held_by_ground) else $error("irq dropped with ground flag set");

    property p_ground_rise_cause;
        $rose(ground_event_flag) |-> $past(take_ok && ground_event);
    endproperty
    a_ground_rise_cause: assert property (p_ground_rise_cause) else $error("ground flag set without ground");

    property p_first_kept;
        capture_order_select && level_event_flag && !clear_level_event_flag && !ctl_write
            |=> $stable(stamp_seconds) && $stable(stamp_hours);
    endproperty
    a_first_kept: assert property (p_first_kept) else $error("first stamp overwritten");

    property p_last_stored;
        !capture_order_select && take_ok && level_event |=> stamp_minutes == $past(now_minutes);
    endproperty
    a_last_stored: assert property (p_last_stored) else $error("latest stamp not stored");

    property p_disabled_quiet;
        capture_disable && !level_event_flag |=> !level_event_flag;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet) else $error("event taken while disabled");

    property p_ctl_write;
        ctl_write |=> capture_disable == $past(reg_wdata[retc_pkg::CTL_DISABLE_BIT])
            && capture_order_select == $past(reg_wdata[retc_pkg::CTL_ORDER_BIT]);
    endproperty
    a_ctl_write: assert property (p_ctl_write) else $error("control write not stored");

    property p_unused_zero;
        ($past(reg_addr) == retc_pkg::ADDR_STAMP_SECONDS) |-> reg_rdata[7] == 1'b0;
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused bit reads one");

    property p_battery_block;
        battery_capture_enable && battery_switch_flag && !ground_event_flag |=> !ground_event_flag;
    endproperty
    a_battery_block: assert property (p_battery_block) else $error("event taken under battery lock");

    property p_clear_ground;
        ground_event_flag && clear_ground_event_flag && !(take_ok && ground_event) |=> !ground_event_flag;
    endproperty
    a_clear_ground: assert property (p_clear_ground) else $error("ground flag not cleared");

    property p_set_wins;
        accept && clear_level_event_flag |=> level_event_flag;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("clear beat an event");

    property p_irq_needs_flag;
        !level_event_flag && !ground_event_flag |-> !stamp_irq;
    endproperty
    a_irq_needs_flag: assert property (p_irq_needs_flag) else $error("irq without a flag");

    property p_ground_stamp;
        !capture_order_select && take_ok && ground_event
            |=> stamp_seconds == $past(now_seconds) && stamp_subsec == $past(now_subsec);
    endproperty
    a_ground_stamp: assert property (p_ground_stamp) else $error("ground stamp not stored");

    property p_joint_load;
        store |=> stamp_hours == $past(hours_fmt) && stamp_seconds == $past(now_seconds);
    endproperty
    a_joint_load: assert property (p_joint_load) else $error("stamp fields split");

    property p_hour_24;
        store && !hour_mode_12 |=> stamp_hours == $past(now_hours_24);
    endproperty
    a_hour_24: assert property (p_hour_24) else $error("24 hour stamp wrong");

    property p_hour_pm;
        store && hour_mode_12 |=> stamp_hours[retc_pkg::HOUR_PM_BIT] == ($past(now_hours_24) >= 6'h12);
    endproperty
    a_hour_pm: assert property (p_hour_pm) else $error("afternoon bit wrong");

    property p_hour_12_range;
        store && hour_mode_12 |=> stamp_hours[4:0] != 5'h00 && stamp_hours[4:0] <= 5'h12;
    endproperty
    a_hour_12_range: assert property (p_hour_12_range) else $error("12 hour stamp out of range");

    property p_disabled_no_store;
        capture_disable |-> !store;
    endproperty
    a_disabled_no_store: assert property (p_disabled_no_store) else $error("stamp loaded while off");

    property p_battery_no_store;
        battery_capture_enable && battery_switch_flag |-> !store;
    endproperty
    a_battery_no_store: assert property (p_battery_no_store) else $error("stamp loaded under lock");

    property p_first_event_store;
        take_ok && level_event && !level_event_flag && !ground_event_flag |-> store;
    endproperty
    a_first_event_store: assert property (p_first_event_store) else $error("fresh event not stored");

    property p_ctl_pad_zero;
        ($past(reg_addr) == retc_pkg::ADDR_STAMP_CONTROL) |-> reg_rdata[5] == 1'b0;
    endproperty
    a_ctl_pad_zero: assert property (p_ctl_pad_zero) else $error("control pad bit reads one");

    property p_hours_pad_zero;
        ($past(reg_addr) == retc_pkg::ADDR_STAMP_HOURS) |-> reg_rdata[7:6] == 2'b00;
    endproperty
    a_hours_pad_zero: assert property (p_hours_pad_zero) else $error("hours pad bits read one");

    property p_ctl_hold;
        !ctl_write |=> $stable(capture_disable) && $stable(capture_order_select);
    endproperty
    a_ctl_hold: assert property (p_ctl_hold) else $error("control bits changed unasked");

    c_ground_event: cover property (take_ok && ground_event ##1 ground_event_flag);
    c_first_kept: cover property (capture_order_select && level_event_flag && accept);
    c_irq_clear: cover property (stamp_irq ##[1:50] !stamp_irq);
    c_set_and_clear: cover property (accept && clear_level_event_flag);

endmodule

// [dv/retc_event_source.sv]
// Model of the external event source driving the multilevel input
`timescale 1ns/10ps
module retc_event_source #(
    parameter int SETTLE_NS = 3
) (
    input  wire retc_pkg::retc_level_t level_req,
    output logic                       below_mid,
    output logic                       at_ground
);
    // Pin at ground also sits below the mid threshold
    assign #SETTLE_NS below_mid = (level_req != retc_pkg::LVL_HIGH);
    assign #SETTLE_NS at_ground = (level_req == retc_pkg::LVL_GND);
endmodule

// [dv/retc_capture_bench.sv]
// Self-checking testbench for the event timestamp capture block
`timescale 1ns/10ps
module retc_capture_bench;
    logic                  clk_sys;
    logic                  resetn;
    retc_pkg::retc_level_t pin_level;
    logic                  below_mid;
    logic                  at_ground;
    logic [4:0]            now_subsec;
    logic [6:0]            now_seconds;
    logic [6:0]            now_minutes;
    logic [5:0]            now_hours_24;
    logic                  hour_mode_12;
    logic                  stamp_irq_enable;
    logic                  battery_capture_enable;
    logic                  battery_switch_flag;
    logic                  clear_level_event_flag;
    logic                  clear_ground_event_flag;
    logic [7:0]            reg_addr;
    logic                  reg_write;
    logic [7:0]            reg_wdata;
    logic [7:0]            reg_rdata;
    logic                  level_event_flag;
    logic                  ground_event_flag;
    logic                  stamp_irq;
    int                    failures;
    int                    num_checks;
    logic [4:0]            e_sub;
    logic [6:0]            e_sec;
    logic [6:0]            e_min;
    logic [5:0]            e_hr;
    logic                  order;
    logic                  dis;

    retc_event_source retc_event_source_i (.level_req(pin_level), .below_mid(below_mid), .at_ground(at_ground));

    retc_capture retc_capture_i (
        .clk_sys(clk_sys), .resetn(resetn),
        .event_input_n_below_mid(below_mid), .event_input_n_at_ground(at_ground),
        .now_subsec(now_subsec), .now_seconds(now_seconds), .now_minutes(now_minutes),
        .now_hours_24(now_hours_24), .hour_mode_12(hour_mode_12), .stamp_irq_enable(stamp_irq_enable),
        .battery_capture_enable(battery_capture_enable), .battery_switch_flag(battery_switch_flag),
        .clear_level_event_flag(clear_level_event_flag), .clear_ground_event_flag(clear_ground_event_flag),
        .reg_addr(reg_addr), .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .level_event_flag(level_event_flag), .ground_event_flag(ground_event_flag), .stamp_irq(stamp_irq)
    );

    function automatic logic [5:0] fmt_hour(logic [5:0] h24, logic m12);
        int h;
        bit pm;
        h = h24[5:4] * 10 + h24[3:0];
        pm = (h >= 12);
        h = h % 12;
        if (h == 0) begin
            h = 12;
        end
        return m12 ? {pm, 1'(h / 10), 4'(h % 10)} : h24;
    endfunction

    task automatic results();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_reg(string what, logic [7:0] a, logic [7:0] exp);
        @(negedge clk_sys) reg_addr = a;
        @(negedge clk_sys) chk(what, exp, reg_rdata);
    endtask

    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(negedge clk_sys);
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        @(negedge clk_sys) reg_write = 1'b0;
    endtask

    task automatic clr(logic l, logic g);
        @(negedge clk_sys);
        clear_level_event_flag = l;
        clear_ground_event_flag = g;
        @(negedge clk_sys);
        clear_level_event_flag = 1'b0;
        clear_ground_event_flag = 1'b0;
        @(negedge clk_sys);
    endtask

    task automatic pin(retc_pkg::retc_level_t lvl);
        @(negedge clk_sys) pin_level = lvl;
        repeat (6) @(negedge clk_sys);
    endtask

    // Fresh legal BCD time; hr below zero picks a random hour
    task automatic new_time(int hr);
        int v;
        @(negedge clk_sys);
        v = $urandom % 16;
        now_subsec = {1'(v / 10), 4'(v % 10)};
        v = $urandom % 60;
        now_seconds = {3'(v / 10), 4'(v % 10)};
        v = $urandom % 60;
        now_minutes = {3'(v / 10), 4'(v % 10)};
        v = (hr < 0) ? $urandom % 24 : hr;
        now_hours_24 = {2'(v / 10), 4'(v % 10)};
        hour_mode_12 = 1'($urandom);
        stamp_irq_enable = 1'($urandom);
    endtask

    task automatic take();
        e_sub = now_subsec;
        e_sec = now_seconds;
        e_min = now_minutes;
        e_hr = fmt_hour(now_hours_24, hour_mode_12);
    endtask

    task automatic chk_flags(logic l, logic g);
        chk("level flag", {7'h00, l}, {7'h00, level_event_flag});
        chk("ground flag", {7'h00, g}, {7'h00, ground_event_flag});
        chk("stamp irq", {7'h00, stamp_irq_enable & (l | g)}, {7'h00, stamp_irq});
    endtask

    task automatic chk_stamp();
        chk_reg("stamp control", retc_pkg::ADDR_STAMP_CONTROL, {order, dis, 1'b0, e_sub});
        chk_reg("stamp seconds", retc_pkg::ADDR_STAMP_SECONDS, {1'b0, e_sec});
        chk_reg("stamp minutes", retc_pkg::ADDR_STAMP_MINUTES, {1'b0, e_min});
        chk_reg("stamp hours", retc_pkg::ADDR_STAMP_HOURS, {2'b00, e_hr});
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    initial begin
        #200000;
        failures++;
        results();
    end

    initial begin
        resetn = 1'b0;
        pin_level = retc_pkg::LVL_HIGH;
        {now_subsec, now_seconds, now_minutes, now_hours_24} = '0;
        {hour_mode_12, stamp_irq_enable, battery_capture_enable, battery_switch_flag} = '0;
        {clear_level_event_flag, clear_ground_event_flag, reg_write} = '0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        failures = 0;
        num_checks = 0;
        order = 1'b0;
        dis = 1'b0;
        void'($urandom(32'hB40BC5E7));
        repeat (5) @(negedge clk_sys);
        resetn = 1'b1;
        chk_flags(1'b0, 1'b0);
        @(negedge clk_sys) reg_addr = retc_pkg::ADDR_STAMP_CONTROL;
        @(negedge clk_sys) chk("control after reset", 8'h00, reg_rdata & 8'hE0);
        chk_reg("unmapped read", 8'h3F, 8'h00);
        for (int i = 0; i < 8; i++) begin
            new_time((i < 2) ? i * 12 : -1);
            take();
            pin(retc_pkg::LVL_MID);
            chk_flags(1'b1, 1'b0);
            chk_stamp();
            pin(retc_pkg::LVL_HIGH);
            chk_flags(1'b1, 1'b0);
            clr(1'b1, 1'b0);
            chk_flags(1'b0, 1'b0);
        end
        new_time(-1);
        take();
        pin(retc_pkg::LVL_GND);
        chk_flags(1'b1, 1'b1);
        chk_stamp();
        clr(1'b1, 1'b0);
        chk_flags(1'b0, 1'b1);
        new_time(-1);
        take();
        pin(retc_pkg::LVL_MID);
        chk_flags(1'b1, 1'b1);
        chk_stamp();
        clr(1'b1, 1'b1);
        pin(retc_pkg::LVL_MID);
        chk_flags(1'b0, 1'b0);
        order = 1'b1;
        wr(retc_pkg::ADDR_STAMP_CONTROL, 8'h9F);
        pin(retc_pkg::LVL_HIGH);
        new_time(-1);
        take();
        pin(retc_pkg::LVL_MID);
        new_time(-1);
        pin(retc_pkg::LVL_HIGH);
        pin(retc_pkg::LVL_GND);
        chk_flags(1'b1, 1'b1);
        chk_stamp();
        clr(1'b1, 1'b1);
        order = 1'b0;
        dis = 1'b1;
        wr(retc_pkg::ADDR_STAMP_CONTROL, 8'h40);
        wr(retc_pkg::ADDR_STAMP_SECONDS, 8'hFF);
        pin(retc_pkg::LVL_HIGH);
        new_time(-1);
        pin(retc_pkg::LVL_MID);
        chk_flags(1'b0, 1'b0);
        chk_stamp();
        dis = 1'b0;
        wr(retc_pkg::ADDR_STAMP_CONTROL, 8'h00);
        pin(retc_pkg::LVL_HIGH);
        battery_capture_enable = 1'b1;
        battery_switch_flag = 1'b1;
        new_time(-1);
        pin(retc_pkg::LVL_GND);
        chk_flags(1'b0, 1'b0);
        chk_stamp();
        pin(retc_pkg::LVL_HIGH);
        battery_switch_flag = 1'b0;
        new_time(-1);
        take();
        pin(retc_pkg::LVL_MID);
        chk_flags(1'b1, 1'b0);
        pin(retc_pkg::LVL_HIGH);
        wr(retc_pkg::ADDR_STAMP_CONTROL, 8'hC0);
        @(negedge clk_sys) resetn = 1'b0;
        repeat (2) @(negedge clk_sys);
        resetn = 1'b1;
        chk_flags(1'b0, 1'b0);
        chk_stamp();
        results();
    end
endmodule
